// File: dmp_top.sv
`timescale 1ns/1ns
`default_nettype none
module dmp_top #(
  parameter longint HOUR_CYCLES = dmp_pkg::HOUR_CYC,
  parameter bit HAS_PLC = 1'b1,
  parameter bit HIGH_CLASS = 1'b0
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic motor_running,
  output logic [2:0] din_first_fn,
  output logic [2:0] din_second_fn,
  output logic [2:0] din_seventh_fn,
  output logic [15:0] vin_setting,
  output logic defaults_load,
  output logic plc_clear,
  output logic fault_clear
);
  if (HOUR_CYCLES < 1 ||
    HOUR_CYCLES > 64'h0001_0000_0000_0000) begin : g_bad_cycles
    $error("hour cycles out of range");
  end
  dmp_pkg::dmp_bus_s bus;
  assign bus = '{reg_addr, reg_wdata, reg_wr, reg_rd};
  logic tsel_q;
  logic [1:0] lock_q;
  logic [3:0] restore_q;
  logic fclr_q;
  dmp_pkg::dmp_din_cfg_s din_q;
  logic [15:0] vin_q;
  logic [15:0] rdata_q;
  logic dload_q;
  logic plc_q;
  logic fault_q;
  dmp_pkg::dmp_state_e st_q;
  logic [4:0] hours;
  logic [15:0] days;
  // write gating by lock setting
  wire wr_lock = bus.wr && bus.addr == dmp_pkg::ADDR_LOCK;
  wire wr_ok = bus.wr && (lock_q == dmp_pkg::LOCK_OPEN);
  wire wr_hours = wr_ok && bus.addr == dmp_pkg::ADDR_HOURS;
  wire wr_days = wr_ok && bus.addr == dmp_pkg::ADDR_DAYS;
  wire wr_tsel = wr_ok && bus.addr == dmp_pkg::ADDR_TSEL;
  wire wr_rst = wr_ok && bus.addr == dmp_pkg::ADDR_RESTORE &&
    st_q == dmp_pkg::ST_IDLE;
  wire wr_fclr = wr_ok && bus.addr == dmp_pkg::ADDR_FCLR;
  wire wr_din = wr_ok && bus.addr == dmp_pkg::ADDR_DIN_CFG;
  wire wr_vin = wr_ok && bus.addr == dmp_pkg::ADDR_VIN;
  wire lock_legal = bus.wdata == 16'(dmp_pkg::LOCK_ALL) ||
    bus.wdata == 16'(dmp_pkg::LOCK_OPEN);
  // restore selector decode
  wire sel_2w = restore_q == dmp_pkg::RST_2W_A ||
    restore_q == dmp_pkg::RST_2W_B || restore_q == dmp_pkg::RST_2W_C;
  wire sel_3w = restore_q == dmp_pkg::RST_3W_A ||
    restore_q == dmp_pkg::RST_3W_B || restore_q == dmp_pkg::RST_3W_C;
  wire sel_plc = restore_q == dmp_pkg::RST_PLC && HAS_PLC;
  wire sel_act = sel_2w || sel_3w || sel_plc;
  wire rst_legal = bus.wdata[15:4] == 12'h0 &&
    (bus.wdata[3:0] == dmp_pkg::RST_NONE ||
    (bus.wdata[3:0] >= dmp_pkg::RST_2W_A &&
    bus.wdata[3:0] <= dmp_pkg::RST_PLC));
  wire [15:0] vin_preset = HIGH_CLASS ? dmp_pkg::VIN_HIGH : dmp_pkg::VIN_LOW;
  wire meter_en = (tsel_q == 1'b0) || motor_running;
  dmp_time_meter #(
    .HOUR_CYCLES(HOUR_CYCLES)
  ) u_meter (
    .clk_sys(clk_sys),
    .srst(srst),
    .count_en(meter_en),
    .load_hours(wr_hours),
    .load_days(wr_days),
    .load_val(bus.wdata),
    .hours_q(hours),
    .days_q(days)
  );
  // read mux
  logic [15:0] rd_mux;
  always_comb begin
    case (bus.addr)
      dmp_pkg::ADDR_HOURS: rd_mux = {11'h0, hours};
      dmp_pkg::ADDR_DAYS: rd_mux = days;
      dmp_pkg::ADDR_TSEL: rd_mux = {15'h0, tsel_q};
      dmp_pkg::ADDR_LOCK: rd_mux = {14'h0, lock_q};
      dmp_pkg::ADDR_RESTORE: rd_mux = {12'h0, restore_q};
      dmp_pkg::ADDR_FCLR: rd_mux = {15'h0, fclr_q};
      dmp_pkg::ADDR_DIN_CFG: rd_mux = {7'h0, din_q};
      dmp_pkg::ADDR_VIN: rd_mux = vin_q;
      default: rd_mux = 16'h0;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (srst) rdata_q <= 16'h0;
    else if (bus.rd) rdata_q <= rd_mux;
    else rdata_q <= 16'h0;
  end
  always_ff @(posedge clk_sys) begin
    if (srst) lock_q <= dmp_pkg::LOCK_RST;
    else if (wr_lock && lock_legal) lock_q <= bus.wdata[1:0];
  end
  always_ff @(posedge clk_sys) begin
    if (srst || st_q == dmp_pkg::ST_LOAD) tsel_q <= 1'b0;
    else if (wr_tsel) tsel_q <= bus.wdata[0];
  end
  // fault history clear pulse
  always_ff @(posedge clk_sys) begin
    if (srst) fclr_q <= 1'b0;
    else if (wr_fclr) fclr_q <= bus.wdata[0];
  end
  always_ff @(posedge clk_sys) begin
    if (srst) fault_q <= 1'b0;
    else fault_q <= wr_fclr && bus.wdata[0];
  end
  // restore sequencer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= dmp_pkg::ST_IDLE;
    end else begin
      case (st_q)
        dmp_pkg::ST_IDLE: if (sel_act) st_q <= dmp_pkg::ST_LOAD;
        dmp_pkg::ST_LOAD: st_q <= dmp_pkg::ST_DONE;
        dmp_pkg::ST_DONE: st_q <= dmp_pkg::ST_IDLE;
        default: st_q <= dmp_pkg::ST_IDLE;
      endcase
    end
  end
  wire in_load = st_q == dmp_pkg::ST_LOAD;
  always_ff @(posedge clk_sys) begin
    if (srst || st_q == dmp_pkg::ST_DONE) restore_q <= dmp_pkg::RST_NONE;
    else if (wr_rst && rst_legal) restore_q <= bus.wdata[3:0];
    else if (st_q == dmp_pkg::ST_IDLE && !sel_act) restore_q <= dmp_pkg::RST_NONE;
  end
  always_ff @(posedge clk_sys) begin
    if (srst) din_q <= dmp_pkg::DIN_2W;
    else if (in_load && sel_2w) din_q <= dmp_pkg::DIN_2W;
    else if (in_load && sel_3w) din_q <= dmp_pkg::DIN_3W;
    else if (wr_din) din_q <= bus.wdata[8:0];
  end
  always_ff @(posedge clk_sys) begin
    if (srst) vin_q <= dmp_pkg::VIN_LOW;
    else if (in_load && (sel_2w || sel_3w)) vin_q <= vin_preset;
    else if (wr_vin) vin_q <= bus.wdata;
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dload_q <= 1'b0;
      plc_q <= 1'b0;
    end else begin
      dload_q <= in_load && (sel_2w || sel_3w);
      plc_q <= in_load && sel_plc;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      din_first_fn <= 3'h0;
      din_second_fn <= 3'h0;
      din_seventh_fn <= 3'h0;
      vin_setting <= 16'h0;
    end else begin
      din_first_fn <= din_q.digital_in_first;
      din_second_fn <= din_q.digital_in_second;
      din_seventh_fn <= din_q.digital_in_seventh;
      vin_setting <= vin_q;
    end
  end
  assign reg_rdata = rdata_q;
  assign defaults_load = dload_q;
  assign plc_clear = plc_q;
  assign fault_clear = fault_q;
endmodule // dmp_top
`default_nettype wire

// File: dmp_pkg.sv
// Summary of operation
// - hours field counts 0 to 23
// - days field counts 0 to 65535
// - mode 0 counts whenever powered
// - mode 1 counts only while running
// - lock 0 blocks all other writes
// - lock 2 allows all writes; 1 reserved
// - restore 0 idle, 2-8 act, others reserved
// - restore 2-7 loads defaults, selector self-clears
// - 2-wire: first fwd, second rev
// - 3-wire: seventh selects direction, run/stop split
// - presets set 220V or 440V input voltage
// - 2,4,6 are 2-wire; 3,5,7 are 3-wire
// - value 8 erases ladder and values
// - no controller variant: no controller clear
// - fault clear 1 erases history; 0 keeps
package dmp_pkg;
  localparam logic [3:0] ADDR_HOURS = 4'h0;
  localparam logic [3:0] ADDR_DAYS = 4'h1;
  localparam logic [3:0] ADDR_TSEL = 4'h2;
  localparam logic [3:0] ADDR_LOCK = 4'h3;
  localparam logic [3:0] ADDR_RESTORE = 4'h4;
  localparam logic [3:0] ADDR_FCLR = 4'h5;
  localparam logic [3:0] ADDR_DIN_CFG = 4'h6;
  localparam logic [3:0] ADDR_VIN = 4'h7;
  localparam logic [4:0] HOURS_MAX = 5'h17;
  localparam logic [15:0] DAYS_MAX = 16'hFFFF;
  localparam logic [1:0] LOCK_ALL = 2'h0;
  localparam logic [1:0] LOCK_OPEN = 2'h2;
  localparam logic [1:0] LOCK_RST = 2'h2;
  localparam logic [3:0] RST_NONE = 4'h0;
  localparam logic [3:0] RST_2W_A = 4'h2;
  localparam logic [3:0] RST_3W_A = 4'h3;
  localparam logic [3:0] RST_2W_B = 4'h4;
  localparam logic [3:0] RST_3W_B = 4'h5;
  localparam logic [3:0] RST_2W_C = 4'h6;
  localparam logic [3:0] RST_3W_C = 4'h7;
  localparam logic [3:0] RST_PLC = 4'h8;
  localparam logic [15:0] VIN_LOW = 16'h00DC;
  localparam logic [15:0] VIN_HIGH = 16'h01B8;
  localparam real HOUR_S = 3600.0;
  localparam real CLK_NS = 10.0;
  localparam longint HOUR_CYC = longint'(HOUR_S * 1.0e9 / CLK_NS);
  // digital input function codes
  localparam logic [2:0] FN_FWD_RUN = 3'h1;
  localparam logic [2:0] FN_REV_RUN = 3'h2;
  localparam logic [2:0] FN_RUN = 3'h3;
  localparam logic [2:0] FN_STOP = 3'h4;
  localparam logic [2:0] FN_DIR = 3'h5;
  localparam logic [2:0] FN_NONE = 3'h0;
  typedef struct packed {
    logic [2:0] digital_in_first;
    logic [2:0] digital_in_second;
    logic [2:0] digital_in_seventh;
  } dmp_din_cfg_s;
  localparam dmp_din_cfg_s DIN_2W = '{FN_FWD_RUN, FN_REV_RUN, FN_NONE};
  localparam dmp_din_cfg_s DIN_3W = '{FN_RUN, FN_STOP, FN_DIR};
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } dmp_bus_s;
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_DONE} dmp_state_e;
endpackage

// File: dmp_time_meter.sv
`timescale 1ns/1ns
`default_nettype none
module dmp_time_meter #(
  parameter longint HOUR_CYCLES = dmp_pkg::HOUR_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic count_en,
  input wire logic load_hours,
  input wire logic load_days,
  input wire logic [15:0] load_val,
  output logic [4:0] hours_q,
  output logic [15:0] days_q
);
  // tick counter is 48 bits wide
  if (HOUR_CYCLES < 1 ||
    HOUR_CYCLES > 64'h0001_0000_0000_0000) begin : g_bad_cycles
    $error("hour cycles out of range");
  end
  logic [47:0] tick_q;
  wire tick_end = (tick_q >= 48'(HOUR_CYCLES - 1));
  wire hour_step = count_en && tick_end;
  wire hour_wrap = (hours_q >= dmp_pkg::HOURS_MAX);
  always_ff @(posedge clk_sys) begin
    if (srst || (count_en && tick_end)) tick_q <= 48'h0;
    else if (count_en) tick_q <= tick_q + 48'h1;
  end
  always_ff @(posedge clk_sys) begin
    if (srst) hours_q <= 5'h0;
    else if (load_hours) hours_q <= (load_val > 16'(dmp_pkg::HOURS_MAX)) ?
      dmp_pkg::HOURS_MAX : load_val[4:0];
    else if (hour_step) hours_q <= hour_wrap ? 5'h0 : hours_q + 5'h1;
  end
  always_ff @(posedge clk_sys) begin
    if (srst) days_q <= 16'h0;
    else if (load_days) days_q <= load_val;
    else if (hour_step && hour_wrap && days_q != dmp_pkg::DAYS_MAX)
      days_q <= days_q + 16'h1;
  end
endmodule // dmp_time_meter
`default_nettype wire

// File: dmp_properties.sv
`timescale 1ns/1ns
`default_nettype none
module dmp_props #(
  parameter bit HAS_PLC = 1'b1,
  parameter bit HIGH_CLASS = 1'b0
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [2:0] din_first_fn,
  input wire logic [2:0] din_second_fn,
  input wire logic [2:0] din_seventh_fn,
  input wire logic [15:0] vin_setting,
  input wire logic defaults_load,
  input wire logic plc_clear,
  input wire logic fault_clear
);
  logic [1:0] lock_q;
  wire logic [15:0] v = reg_wdata;
  wire logic open_w = lock_q == 2'h2;
  wire logic rs_wr = reg_wr && reg_addr == 4'h4 && open_w;
  wire logic preset = rs_wr && v > 16'h1 && v < 16'h8;
  wire logic lk_wr = reg_wr && reg_addr == 4'h3;
  // mirror of the write lock
  always_ff @(posedge clk_sys) begin
    if (srst) lock_q <= 2'h2;
    else if (lk_wr && (v == 16'h0 || v == 16'h2)) lock_q <= v[1:0];
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  preset_load_a: assert property (preset |-> ##3 defaults_load)
    else $error("preset did not load defaults");
  pulse_one_a: assert property (defaults_load |=> !defaults_load)
    else $error("defaults pulse too long");
  two_wire_a: assert property (preset && !v[0] |-> ##4
    din_first_fn == 3'h1 && din_second_fn == 3'h2) else $error("bad 2-wire");
  three_wire_a: assert property (preset && v[0] |-> ##4
    {din_first_fn, din_second_fn, din_seventh_fn} == 9'h0E5)
    else $error("bad 3-wire");
  vin_preset_a: assert property (preset |-> ##4
    vin_setting == (HIGH_CLASS ? 16'h01B8 : 16'h00DC))
    else $error("bad input voltage");
  plc_clr_a: assert property (
    HAS_PLC && rs_wr && v == 16'h8 |-> ##[1:3] plc_clear)
    else $error("no controller clear");
  no_plc_a: assert property (
    !HAS_PLC && rs_wr && v == 16'h8 |-> ##1 !plc_clear [*3])
    else $error("controller clear without controller");
  locked_restore_a: assert property (
    reg_wr && reg_addr == 4'h4 && lock_q == 2'h0 |-> ##1 !defaults_load [*3])
    else $error("locked write acted");
  reserved_sel_a: assert property (
    rs_wr && (v == 16'h1 || v > 16'h8) |-> ##1 !(defaults_load || plc_clear) [*3])
    else $error("reserved selector acted");
  fault_clr_a: assert property (fault_clear ==
    $past(reg_wr && reg_addr == 4'h5 && v == 16'h1 && open_w))
    else $error("bad fault clear");
endmodule // dmp_props
bind dmp_top dmp_props #(.HAS_PLC(HAS_PLC), .HIGH_CLASS(HIGH_CLASS))
  u_props (.clk_sys(clk_sys), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .din_first_fn(din_first_fn), .din_second_fn(din_second_fn),
  .din_seventh_fn(din_seventh_fn), .vin_setting(vin_setting),
  .defaults_load(defaults_load), .plc_clear(plc_clear),
  .fault_clear(fault_clear));
`default_nettype wire

// File: drive_maintenance_parameters_test.sv
`timescale 1ns/1ns
`default_nettype none
module drive_maintenance_parameters_test;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic motor_running = 1'b0;
  logic [15:0] reg_rdata, vin_setting, rv;
  logic [2:0] din_first_fn, din_second_fn, din_seventh_fn;
  logic defaults_load, plc_clear, fault_clear;
  logic [15:0] vin_b;
  logic plc_b;
  int n_plc_b = 0;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_def = 0;
  int n_plc = 0;
  int n_fc = 0;
  wire logic [15:0] din_w = {7'h0, din_first_fn, din_second_fn, din_seventh_fn};
  dmp_top #(.HOUR_CYCLES(4)) uut (.clk_sys(clk_sys), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motor_running(motor_running),
    .din_first_fn(din_first_fn), .din_second_fn(din_second_fn),
    .din_seventh_fn(din_seventh_fn), .vin_setting(vin_setting),
    .defaults_load(defaults_load), .plc_clear(plc_clear),
    .fault_clear(fault_clear));
  dmp_top #(.HOUR_CYCLES(4), .HAS_PLC(1'b0), .HIGH_CLASS(1'b1)) uut_b (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(),
    .motor_running(motor_running), .din_first_fn(), .din_second_fn(),
    .din_seventh_fn(), .vin_setting(vin_b), .defaults_load(),
    .plc_clear(plc_b), .fault_clear());
  always #5 clk_sys = ~clk_sys;
  // pulse counters and run limit
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (defaults_load === 1'b1) n_def <= n_def + 1;
    if (plc_clear === 1'b1) n_plc <= n_plc + 1;
    if (plc_b === 1'b1) n_plc_b <= n_plc_b + 1;
    if (fault_clear === 1'b1) n_fc <= n_fc + 1;
    if (cyc == 2000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk(din_w, 16'h0050);
    rd(4'h3);
    chk(rv, 16'h2);
    wr(4'h2, 16'h1);
    wr(4'h1, 16'h5);
    wr(4'h0, 16'h1E);
    rd(4'h0);
    chk(rv, 16'h17);
    @(posedge clk_sys);
    motor_running <= 1'b1;
    repeat (4) @(posedge clk_sys);
    motor_running <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(4'h0);
    chk(rv, 16'h0);
    rd(4'h1);
    chk(rv, 16'h6);
    wr(4'h2, 16'h0);
    repeat (8) @(posedge clk_sys);
    rd(4'h0);
    chk({15'h0, rv != 16'h0}, 16'h1);
    wr(4'h3, 16'h0);
    wr(4'h5, 16'h1);
    wr(4'h4, 16'h3);
    wr(4'h3, 16'h1);
    rd(4'h4);
    chk(rv, 16'h0);
    rd(4'h3);
    chk(rv, 16'h0);
    chk(16'(n_def + n_fc), 16'h0);
    wr(4'h3, 16'h2);
    for (int v = 2; v < 8; v++) begin
      wr(4'h7, 16'h0100);
      rd(4'h7);
      chk(rv, 16'h0100);
      wr(4'h4, 16'(v));
      repeat (3) @(posedge clk_sys);
      #1 chk(din_w, v[0] ? 16'h00E5 : 16'h0050);
      chk(vin_setting, 16'h00DC);
      chk(vin_b, 16'h01B8);
      rd(4'h4);
      chk(rv, 16'h0);
    end
    wr(4'h4, 16'h1);
    wr(4'h4, 16'h9);
    wr(4'h5, 16'h0);
    repeat (4) @(posedge clk_sys);
    #1 chk(16'(n_def + n_fc), 16'h6);
    wr(4'h4, 16'h8);
    repeat (4) @(posedge clk_sys);
    #1 chk(16'(n_plc), 16'h1);
    chk(16'(n_plc_b), 16'h0);
    wr(4'h5, 16'h1);
    @(posedge clk_sys);
    #1 chk(16'(n_fc), 16'h1);
    rd(4'hF);
    chk(rv, 16'h0);
    tally_and_finish();
  end
endmodule // drive_maintenance_parameters_test
`default_nettype wire
